/* File: logic/vtd_pkg.sv */
// How it works
// RULE1 - Detector runs and makes events only while the power enable bit is one.
// RULE2 - With stop-in-idle set, detection halts while the device is idle.
// RULE3 - Direction one: event at or above trip; zero: at or below.
// RULE4 - Interrupt flag sets when voltage passes trip point in chosen direction.
// RULE5 - Enabled set flag drives the interrupt request output.
// RULE6 - Status bit shows one when the band-gap voltage is stable.
// RULE7 - Reference-stable bit shows reference state; no flag while it is zero.
// RULE8 - Software keeps the interrupt disabled until reference-stable reads one.
// RULE9 - Limit code all ones selects the external analog input pin.
// RULE10 - Codes 1110 down to 0000 select internal trip points 1 to 15.
// RULE11 - Unimplemented control bits read zero and ignore writes.
// RULE12 - Comparator is synchronised; flag sets once per qualifying crossing.
`default_nettype none
package vtd_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CLEAR   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h0C;

    // Control register field positions
    localparam int BIT_POWER_EN   = 15;
    localparam int BIT_STOP_IDLE  = 13;
    localparam int BIT_DIRECTION  = 7;
    localparam int BIT_BANDGAP_OK = 6;
    localparam int BIT_REF_OK     = 5;
    localparam int LIMIT_MSB      = 3;
    localparam int LIMIT_LSB      = 0;

    // Writable control bits: 15, 13, 7, 3..0
    localparam logic [15:0] CONTROL_WMASK = 16'hA08F;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // Event status layout
    localparam int EVT_TRIP      = 0;
    localparam int EVT_W         = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 1'h0;

    // Limit code that routes the external input
    localparam logic [3:0] LIMIT_EXTERNAL = 4'hF;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       power_en;
        logic       stop_idle;
        logic       direction;
        logic [3:0] limit;
    } vtd_ctrl_t;

    localparam vtd_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 4'h0};

    // Comparator side inputs, grouped after synchronisation
    typedef struct packed {
        logic above;
        logic bandgap_ok;
        logic ref_ok;
    } vtd_analog_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_RESP = 2'b01
    } vtd_rd_state_t;

endpackage
`default_nettype wire

/* File: logic/vtd_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module vtd_sync
    import vtd_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg [SYNC_STAGES];

    // First stage feeds only the second
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            stage_reg[0] <= async_in;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign sync_out = stage_reg[SYNC_STAGES-1];

endmodule
`default_nettype wire

/* File: logic/vtd_top.sv */
`timescale 1ns/1ns
`default_nettype none
module vtd_top
    import vtd_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Analog front end, asynchronous
    input  wire logic              cmp_above,
    input  wire logic              bandgap_stable,
    input  wire logic              reference_stable,
    // Core power state, same clock
    input  wire logic              idle_mode,
    // Analog control
    output logic                   analog_power_on,
    output logic                   external_trip_input_sel,
    output logic [3:0]             trip_point_num,
    // Interrupt
    output logic                   irq
);

    // Register index decode
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CONTROL: reg_sel = 2'h0;
            OFS_STATUS:  reg_sel = 2'h1;
            OFS_CLEAR:   reg_sel = 2'h2;
            default:     reg_sel = 2'h3;
        endcase
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == OFS_CONTROL) || (a == OFS_STATUS) ||
                  (a == OFS_CLEAR) || (a == OFS_ENABLE);
    endfunction

    // Limit code to internal trip point number, 0 when external
    function automatic logic [3:0] trip_num(input logic [3:0] code);
        if (code == LIMIT_EXTERNAL) begin // RULE9
            trip_num = 4'h0;
        end else begin
            trip_num = 4'hF - code; // RULE10
        end
    endfunction

    // Synchronised analog inputs
    vtd_analog_t ana;
    logic [2:0]  ana_vec;

    vtd_sync #(
        .WIDTH (3)
    ) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({cmp_above, bandgap_stable, reference_stable}),
        .sync_out (ana_vec)
    ); // RULE12

    assign ana = vtd_analog_t'(ana_vec);

    // Register state
    vtd_ctrl_t         ctrl_reg,    ctrl_next;
    logic [EVT_W-1:0]  status_reg,  status_next;
    logic [EVT_W-1:0]  enable_reg,  enable_next;
    logic              prev_reg,    prev_next;
    logic              irq_reg,     irq_next;
    logic              pwr_reg,     pwr_next;
    logic              ext_reg,     ext_next;
    logic [3:0]        tnum_reg,    tnum_next;

    // Write channel state
    logic              aw_have_reg, aw_have_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic              w_have_reg,  w_have_next;
    logic [DATA_W-1:0] w_data_reg,  w_data_next;
    logic [3:0]        w_strb_reg,  w_strb_next;
    logic              bvalid_reg,  bvalid_next;
    logic [1:0]        bresp_reg,   bresp_next;

    // Read channel state
    vtd_rd_state_t     rd_reg,      rd_next;
    logic [DATA_W-1:0] rdata_reg,   rdata_next;
    logic [1:0]        rresp_reg,   rresp_next;

    logic              do_write;
    logic [15:0]       control_view;
    logic              active;
    logic              condition;
    logic [15:0]       wr_word;

    // Control register as software sees it
    always_comb begin
        control_view                 = 16'h0000; // RULE11
        control_view[BIT_POWER_EN]   = ctrl_reg.power_en;
        control_view[BIT_STOP_IDLE]  = ctrl_reg.stop_idle;
        control_view[BIT_DIRECTION]  = ctrl_reg.direction;
        control_view[BIT_BANDGAP_OK] = ana.bandgap_ok; // RULE6
        control_view[BIT_REF_OK]     = ana.ref_ok; // RULE7
        control_view[LIMIT_MSB:LIMIT_LSB] = ctrl_reg.limit;
    end

    // Detector running, stopped by power, idle with stop-in-idle set, or unstable reference
    assign active = ctrl_reg.power_en // RULE1
                  && !(ctrl_reg.stop_idle && idle_mode) // RULE2
                  && ana.ref_ok; // RULE7
    assign condition = ctrl_reg.direction ? ana.above : !ana.above; // RULE3

    // Write channel
    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next  = w_have_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = reg_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wr_word  = {w_strb_reg[1] ? w_data_reg[15:8] : control_view[15:8],
                       w_strb_reg[0] ? w_data_reg[7:0] : control_view[7:0]};

    // Control, event and interrupt state
    always_comb begin
        ctrl_next   = ctrl_reg;
        enable_next = enable_reg;
        status_next = status_reg;
        prev_next   = active && condition;
        if (do_write && reg_sel(aw_addr_reg) == 2'h0) begin
            ctrl_next.power_en  = wr_word[BIT_POWER_EN];
            ctrl_next.stop_idle = wr_word[BIT_STOP_IDLE];
            ctrl_next.direction = wr_word[BIT_DIRECTION];
            ctrl_next.limit     = wr_word[LIMIT_MSB:LIMIT_LSB];
        end
        if (do_write && aw_addr_reg == OFS_ENABLE && w_strb_reg[0]) begin
            enable_next = w_data_reg[EVT_W-1:0];
        end
        if (do_write && reg_sel(aw_addr_reg) == 2'h2 && w_strb_reg[0]) begin
            status_next = status_reg & ~w_data_reg[EVT_W-1:0];
        end
        // Set after clear: a crossing in the clearing cycle is kept
        if (active && condition && !prev_reg) begin // RULE12
            status_next[EVT_TRIP] = 1'b1; // RULE4
        end
        irq_next  = |(status_next & enable_next); // RULE5
        pwr_next  = ctrl_next.power_en; // RULE1
        ext_next  = (ctrl_next.limit == LIMIT_EXTERNAL); // RULE9
        tnum_next = trip_num(ctrl_next.limit); // RULE10
    end

    // Read channel
    always_comb begin
        rd_next    = rd_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rd_reg)
            RD_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    rd_next    = RD_RESP;
                    rdata_next = '0;
                    rresp_next = RESP_OKAY;
                    case (reg_sel(s_axi_araddr))
                        2'h0: rdata_next[15:0] = control_view;
                        2'h1: rdata_next[EVT_W-1:0] = status_reg;
                        2'h2: rdata_next = '0;
                        default: begin
                            if (s_axi_araddr == OFS_ENABLE) begin
                                rdata_next[EVT_W-1:0] = enable_reg;
                            end else begin
                                rresp_next = RESP_SLVERR;
                            end
                        end
                    endcase
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    rd_next = RD_IDLE;
                end
            end
            default: rd_next = RD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg    <= CTRL_RESET;
            status_reg  <= EVT_RESET;
            enable_reg  <= EVT_RESET;
            prev_reg    <= 1'b0;
            irq_reg     <= 1'b0;
            pwr_reg     <= 1'b0;
            ext_reg     <= 1'b0;
            tnum_reg    <= 4'hF;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_have_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rd_reg      <= RD_IDLE;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else begin
            ctrl_reg    <= ctrl_next;
            status_reg  <= status_next;
            enable_reg  <= enable_next;
            prev_reg    <= prev_next;
            irq_reg     <= irq_next;
            pwr_reg     <= pwr_next;
            ext_reg     <= ext_next;
            tnum_reg    <= tnum_next;
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg  <= w_have_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rd_reg      <= rd_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // Ready signals are registered state inverted
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;
    logic rvalid_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
        end else begin
            awready_reg <= !aw_have_next && !bvalid_next;
            wready_reg  <= !w_have_next && !bvalid_next;
            arready_reg <= (rd_next == RD_IDLE);
            rvalid_reg  <= (rd_next == RD_RESP);
        end
    end

    assign s_axi_awready           = awready_reg;
    assign s_axi_wready            = wready_reg;
    assign s_axi_bvalid            = bvalid_reg;
    assign s_axi_bresp             = bresp_reg;
    assign s_axi_arready           = arready_reg;
    assign s_axi_rvalid            = rvalid_reg;
    assign s_axi_rdata             = rdata_reg;
    assign s_axi_rresp             = rresp_reg;
    assign analog_power_on         = pwr_reg;
    assign external_trip_input_sel = ext_reg;
    assign trip_point_num          = tnum_reg;
    assign irq                     = irq_reg;

endmodule
`default_nettype wire

/* File: tb/vtd_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module vtd_properties
    import vtd_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // Bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // Detector
    input wire logic       reference_stable,
    input wire logic       analog_power_on,
    input wire logic       external_trip_input_sel,
    input wire logic [3:0] trip_point_num,
    input wire logic       irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Interrupt rise not caused by a register write
    sequence s_irq_rise;
        $rose(irq) && !s_axi_bvalid && !$past(s_axi_bvalid);
    endsequence

    a_trip_decode: assert property (
        external_trip_input_sel == (trip_point_num == 4'h0))
        else $error("trip selection and trip number disagree");
    a_irq_needs_power: assert property (
        s_irq_rise |-> $past(analog_power_on))
        else $error("interrupt raised while detector off");
    a_irq_needs_ref: assert property (
        s_irq_rise |-> $past(reference_stable, 2) || $past(reference_stable, 3))
        else $error("interrupt raised while reference unstable");
    a_write_latency: assert property (
        s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_write_block: assert property (
        s_wr_both |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels not blocked");
    a_ready_return: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1
        (s_axi_awready && s_axi_wready))
        else $error("write channels not reopened");
    a_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    a_read_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
endmodule

bind vtd_top vtd_properties i_props (
    .ref_clk(ref_clk), .nrst(nrst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_stable(reference_stable), .analog_power_on(analog_power_on),
    .external_trip_input_sel(external_trip_input_sel),
    .trip_point_num(trip_point_num), .irq(irq)
);
`default_nettype wire

/* File: tb/test_voltage_trip_detect_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_voltage_trip_detect_control import vtd_pkg::*;;
    logic              ref_clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0;
    logic              bready = 1'b0, arv = 1'b0, rready = 1'b0, cmp = 1'b0;
    logic              bg = 1'b0, rs = 1'b0, idle = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [1:0]        bresp, rresp;
    logic              awr, wr_, bv, arr, rv, pwr, ext, irq;
    logic [3:0]        tpn;
    int                miscompares = 0, comparisons = 0;

    vtd_top i_dut (
        .ref_clk(ref_clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .cmp_above(cmp), .bandgap_stable(bg),
        .reference_stable(rs), .idle_mode(idle), .analog_power_on(pwr),
        .external_trip_input_sel(ext), .trip_point_num(tpn), .irq(irq)
    );

    always #4 ref_clk = ~ref_clk;

    task automatic check(input string n, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            ad = ad | awr;
            dd = dd | wr_;
            if (ad) awv <= 1'b0;
            if (dd) wv <= 1'b0;
        end while (!(ad && dd));
        do @(posedge ref_clk); while (bv !== 1'b1);
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge ref_clk); while (rv !== 1'b1);
        rready <= 1'b0;
        check("rdata", rdata, ed);
        check("rresp", 32'(rresp), 32'(er));
    endtask

    task automatic t_reset;
        rd(OFS_CONTROL, 32'h0, RESP_OKAY);
        rd(OFS_ENABLE, 32'h0, RESP_OKAY);
        rd(OFS_CLEAR, 32'h0, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
        wr(OFS_STATUS, 32'h1, RESP_OKAY);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        check("trip_num", 32'(tpn), 32'hF);
        $display("reset test done");
    endtask

    task automatic t_ctrl;
        bg <= 1'b1;
        rs <= 1'b1;
        wr(OFS_CONTROL, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_CONTROL, 32'h0000A0EF, RESP_OKAY);
        check("ext_sel", 32'(ext), 32'h1);
        check("trip_num", 32'(tpn), 32'h0);
        check("power", 32'(pwr), 32'h1);
        for (int c = 0; c < 15; c++) begin
            wr(OFS_CONTROL, 32'(c), RESP_OKAY);
            repeat (2) @(posedge ref_clk);
            check("trip_num", 32'(tpn), 32'(15 - c));
            check("ext_sel", 32'(ext), 32'h0);
        end
        bg <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(OFS_CONTROL, 32'h0000002E, RESP_OKAY);
        $display("control test done");
    endtask

    task automatic t_event;
        wr(OFS_ENABLE, 32'h1, RESP_OKAY);
        wr(OFS_CONTROL, 32'h00008080, RESP_OKAY);
        cmp <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check("irq", 32'(irq), 32'h1);
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_CLEAR, 32'h1, RESP_OKAY);
        repeat (6) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        check("irq", 32'(irq), 32'h0);
        wr(OFS_CONTROL, 32'h00008000, RESP_OKAY);
        cmp <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_ENABLE, 32'h0, RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        check("irq", 32'(irq), 32'h0);
        wr(OFS_ENABLE, 32'h1, RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        check("irq", 32'(irq), 32'h1);
        wr(OFS_CLEAR, 32'h1, RESP_OKAY);
        $display("event test done");
    endtask

    task automatic t_blocked;
        wr(OFS_CONTROL, 32'h00000080, RESP_OKAY);
        cmp <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        check("power", 32'(pwr), 32'h0);
        cmp <= 1'b0;
        idle <= 1'b1;
        wr(OFS_CONTROL, 32'h0000A080, RESP_OKAY);
        cmp <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        idle <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_CLEAR, 32'h1, RESP_OKAY);
        cmp <= 1'b0;
        wr(OFS_CONTROL, 32'h00008080, RESP_OKAY);
        idle <= 1'b1;
        repeat (3) @(posedge ref_clk);
        cmp <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_CLEAR, 32'h1, RESP_OKAY);
        wr(OFS_ENABLE, 32'h0, RESP_OKAY);
        check("irq", 32'(irq), 32'h0);
        cmp <= 1'b0;
        rs <= 1'b0;
        repeat (5) @(posedge ref_clk);
        cmp <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        rd(OFS_CONTROL, 32'h00008080, RESP_OKAY);
        $display("blocked test done");
    endtask

    task automatic finish_test;
        $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset;
        t_ctrl;
        t_event;
        t_blocked;
        finish_test;
    end

    // Runs take a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finish_test;
    end
endmodule
`default_nettype wire
